/* hdl/ebad_top.sv */
// Purpose: Address latch, board match and socket select of EPROM board
// Assumes: All bus pins asynchronous to i_clock, two-stage synchronised
// Notes: Programming sequencer timing lives outside this block
//
// Behaviour
// - Board answers one switch-chosen 4 KiB block
// - Each socket owns a fixed 256-byte slice
// - Whole window claimed whatever sockets populated
// - Low address passes on read, held on write
// - Low high-byte nibble captured at strobe fall
// - Two captured bits give one-hot column select
// - Next two bits give one-hot row enable
// - Modes: read, erase verify, program
// - Upper nibble captured, compared against switch
// - Data drivers enabled only during read command
// - Boot force makes top address bit one
// - Read mode never programs on writes, reads normal
`timescale 1ns/1ps
`include "ebad_defs.svh"
module ebad_top #(
  parameter int ADDR_W = `EBAD_ADDR_W
) (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic [7:0] i_mux_addr,
  input wire logic i_address_strobe_pulse,
  input wire logic i_second_timing_pulse,
  input wire logic i_mem_read_cmd_n,
  input wire logic i_mem_write_cmd_n,
  input wire logic i_boot_high_force,
  input wire logic [3:0] i_board_switch,
  input wire logic i_mode_prog_switch,
  input wire logic [7:0] i_socket_data,
  input wire logic [7:0] i_data,
  output logic [7:0] o_data,
  output logic o_data_oe,
  output logic [7:0] o_socket_addr,
  output logic [3:0] o_column_select,
  output logic [3:0] o_row_enable_n,
  output logic o_board_enable,
  output logic o_erase_verify,
  output logic o_prog_active,
  output logic o_prog_strobe,
  output logic [7:0] o_prog_data
);

  if (ADDR_W != 8) begin : g_width_check
    $error("ebad_top serves an 8-bit multiplexed address only");
  end

  localparam int IN_W = 34;

  logic [IN_W-1:0] raw_in;
  logic [IN_W-1:0] meta_ff;
  logic [IN_W-1:0] sync_ff;
  logic strobe_d_ff;
  logic tpb_d_ff;
  logic [3:0] nib_ff;
  logic [3:0] blk_ff;
  logic match_ff;
  logic [7:0] lo_ff;
  logic [7:0] data_ff;
  logic prog_strobe_ff;
  logic [7:0] prog_data_ff;
  ebad_pkg::ebad_mode_t mode_ff;
  ebad_pkg::ebad_mode_t nxt_mode;

  // Commands inverted before sync so reset leaves them idle
  assign raw_in = {i_mux_addr, i_address_strobe_pulse,
                   i_second_timing_pulse, ~i_mem_read_cmd_n,
                   ~i_mem_write_cmd_n, i_boot_high_force, i_board_switch,
                   i_mode_prog_switch, i_socket_data, i_data};

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= raw_in;
      sync_ff <= meta_ff;
    end
  end

  wire [7:0] addr_s = sync_ff[33:26];
  wire strobe_s = sync_ff[25];
  wire tpb_s = sync_ff[24];
  wire rd_s = sync_ff[23];
  wire wr_s = sync_ff[22];
  wire boot_s = sync_ff[21];
  wire [3:0] switch_s = sync_ff[20:17];
  wire prog_sw_s = sync_ff[16];
  wire [7:0] sock_data_s = sync_ff[15:8];
  wire [7:0] bus_data_s = sync_ff[7:0];

  // Capture point is the trailing edge of the strobe
  wire strobe_fall = strobe_d_ff & ~strobe_s;
  wire tpb_rise = tpb_s & ~tpb_d_ff;
  wire access_s = rd_s | wr_s;

  // Upper nibble of the high byte, top bit forced by boot input
  wire [3:0] blk_in = addr_s[`EBAD_BLK_MSB:`EBAD_BLK_LSB];
  wire [3:0] nxt_blk = strobe_fall ?
    (blk_in | {boot_s, 3'h0}) : blk_ff;
  wire [3:0] nxt_nib = strobe_fall ?
    addr_s[`EBAD_SEL_MSB:`EBAD_SEL_LSB] : nib_ff;
  // Match on the full block, all sixteen slices claimed
  wire nxt_match = (nxt_blk == switch_s);
  // Low byte flows on read, frozen for the whole write
  wire [7:0] nxt_lo = wr_s ? lo_ff : addr_s;
  wire prog_hit = (mode_ff == ebad_pkg::ebad_mode_program) & prog_sw_s
                  & match_ff & wr_s & tpb_rise;
  wire [7:0] nxt_prog_data = prog_hit ? bus_data_s : prog_data_ff;

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      strobe_d_ff <= 1'b0;
      tpb_d_ff <= 1'b0;
      nib_ff <= `EBAD_NIB_RST;
      blk_ff <= `EBAD_NIB_RST;
      match_ff <= 1'b0;
      lo_ff <= `EBAD_BYTE_RST;
    end else begin
      strobe_d_ff <= strobe_s;
      tpb_d_ff <= tpb_s;
      nib_ff <= nxt_nib;
      blk_ff <= nxt_blk;
      match_ff <= nxt_match;
      lo_ff <= nxt_lo;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      data_ff <= `EBAD_BYTE_RST;
      prog_strobe_ff <= 1'b0;
      prog_data_ff <= `EBAD_BYTE_RST;
      mode_ff <= ebad_pkg::ebad_mode_read;
    end else begin
      data_ff <= sock_data_s;
      prog_strobe_ff <= prog_hit;
      prog_data_ff <= nxt_prog_data;
      mode_ff <= nxt_mode;
    end
  end

  // Switch in read position always wins; otherwise read goes to verify, then matched access kind decides
  always_comb begin
    nxt_mode = mode_ff;
    case (mode_ff)
      ebad_pkg::ebad_mode_read: begin
        if (prog_sw_s) begin
          nxt_mode = ebad_pkg::ebad_mode_verify;
        end
      end
      ebad_pkg::ebad_mode_verify: begin
        if (!prog_sw_s) begin
          nxt_mode = ebad_pkg::ebad_mode_read;
        end else if (match_ff & wr_s) begin
          nxt_mode = ebad_pkg::ebad_mode_program;
        end
      end
      ebad_pkg::ebad_mode_program: begin
        if (!prog_sw_s) begin
          nxt_mode = ebad_pkg::ebad_mode_read;
        end else if (match_ff & rd_s) begin
          nxt_mode = ebad_pkg::ebad_mode_verify;
        end
      end
      default: begin
        nxt_mode = ebad_pkg::ebad_mode_read;
      end
    endcase
  end

  ebad_sel_if sel ();

  assign sel.nib = nib_ff;
  assign sel.en = match_ff & access_s;

  ebad_decode u_decode (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .sel(sel)
  );

  assign o_data = data_ff;
  assign o_data_oe = match_ff & rd_s;
  assign o_socket_addr = lo_ff;
  assign o_column_select = sel.col;
  assign o_row_enable_n = sel.row_n;
  assign o_board_enable = match_ff;
  assign o_erase_verify = (mode_ff == ebad_pkg::ebad_mode_verify);
  assign o_prog_active = (mode_ff == ebad_pkg::ebad_mode_program);
  assign o_prog_strobe = prog_strobe_ff;
  assign o_prog_data = prog_data_ff;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);

  sequence s_strobe_fall;
    strobe_d_ff && !strobe_s;
  endsequence

  sequence s_idle_then_access;
    !access_s ##1 access_s;
  endsequence

  a_nib_capture: assert property (s_strobe_fall |=>
    nib_ff == $past(addr_s[3:0]))
    else $error("low nibble not captured at strobe fall");
  a_nib_hold: assert property (!strobe_fall |=> $stable(nib_ff))
    else $error("captured nibble moved without strobe");
  a_boot_force: assert property ((s_strobe_fall and boot_s) |=>
    blk_ff[3])
    else $error("boot force did not set top bit");
  a_block_match: assert property (s_strobe_fall |=>
    match_ff == (($past(blk_in) | {$past(boot_s), 3'h0})
    == $past(switch_s)))
    else $error("board match disagrees with switch");
  a_select_gate: assert property (s_idle_then_access ##0 match_ff |=>
    (|o_column_select) && !(&o_row_enable_n))
    else $error("matched access gave no socket select");
  a_select_cause: assert property ((|o_column_select) |->
    $past(match_ff) && $past(access_s))
    else $error("socket selected without match and command");
  a_data_drive: assert property (o_data_oe |->
    match_ff && !$past(i_mem_read_cmd_n, 2))
    else $error("data drivers on outside read");
  a_lo_hold: assert property (wr_s ##1 wr_s |-> $stable(o_socket_addr))
    else $error("low address moved during write");
  a_lo_pass: assert property (!wr_s |=>
    o_socket_addr == $past(addr_s))
    else $error("low address not passed through");
  a_read_no_prog: assert property (!prog_sw_s |=>
    !o_prog_strobe [*2])
    else $error("program strobe in read mode");

endmodule

/* hdl/ebad_defs.svh */
// Purpose: Shared constants of the EPROM board address decoder
// Assumes: Included by its bare name
// Notes: Positions refer to bits of the multiplexed address byte
`ifndef EBAD_DEFS_SVH
`define EBAD_DEFS_SVH

`define EBAD_ADDR_W 8
`define EBAD_NIB_W 4
`define EBAD_BLK_MSB 7
`define EBAD_BLK_LSB 4
`define EBAD_SEL_MSB 3
`define EBAD_SEL_LSB 0
`define EBAD_COL_MSB 1
`define EBAD_COL_LSB 0
`define EBAD_ROW_MSB 3
`define EBAD_ROW_LSB 2
`define EBAD_BOOT_BIT 3
`define EBAD_BYTE_RST 8'h00
`define EBAD_NIB_RST 4'h0
`define EBAD_COL_RST 4'h0
`define EBAD_ROW_N_RST 4'hf

`endif

/* hdl/ebad_pkg.sv */
// Purpose: Types of the EPROM board address decoder
// Assumes: Nothing imported; users write ebad_pkg::name
// Notes: Mode follows the mode switch and the access kind
package ebad_pkg;

  typedef enum logic [1:0] {
    ebad_mode_read = 2'b00,
    ebad_mode_verify = 2'b01,
    ebad_mode_program = 2'b10
  } ebad_mode_t;

  typedef logic [3:0] ebad_nib_t;

endpackage

/* hdl/ebad_sel_if.sv */
// Purpose: Carrier between address capture and socket decoder
// Assumes: One instance inside the top module
// Notes: Row enables are active low
`timescale 1ns/1ps
interface ebad_sel_if;
  ebad_pkg::ebad_nib_t nib;
  logic en;
  logic [3:0] col;
  logic [3:0] row_n;
  modport cap (output nib, output en, input col, input row_n);
  modport dec (input nib, input en, output col, output row_n);
endinterface

/* hdl/ebad_decode.sv */
// Purpose: Socket matrix decode into column selects and row enables
// Assumes: Nibble and enable come from the same clock domain
// Notes: Outputs are registered, all idle while not enabled
`timescale 1ns/1ps
`include "ebad_defs.svh"
module ebad_decode (
  input wire logic i_clock,
  input wire logic i_reset,
  ebad_sel_if.dec sel
);

  function automatic logic [3:0] ebad_dec2(input logic [1:0] code);
    ebad_dec2 = 4'h1 << code;
  endfunction

  logic [3:0] col_ff;
  logic [3:0] row_n_ff;
  logic [3:0] nxt_col;
  logic [3:0] nxt_row_n;

  // One column and one row per code, only while enabled
  assign nxt_col = sel.en ?
    ebad_dec2(sel.nib[`EBAD_COL_MSB:`EBAD_COL_LSB]) : `EBAD_COL_RST;
  assign nxt_row_n = sel.en ?
    ~ebad_dec2(sel.nib[`EBAD_ROW_MSB:`EBAD_ROW_LSB]) : `EBAD_ROW_N_RST;

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      col_ff <= `EBAD_COL_RST;
      row_n_ff <= `EBAD_ROW_N_RST;
    end else begin
      col_ff <= nxt_col;
      row_n_ff <= nxt_row_n;
    end
  end

  assign sel.col = col_ff;
  assign sel.row_n = row_n_ff;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);

  a_col_one_hot: assert property ($onehot0(col_ff))
    else $error("column selects not mutually exclusive");
  a_row_one_hot: assert property ($onehot0(~row_n_ff))
    else $error("row enables not mutually exclusive");
  a_col_row_pair: assert property ((|col_ff) == (|(~row_n_ff)))
    else $error("column and row selects disagree");
  a_col_code: assert property (sel.en |=>
    col_ff == (4'h1 << $past(sel.nib[1:0])))
    else $error("column select does not match code");
  a_row_code: assert property (sel.en |=>
    ~row_n_ff == (4'h1 << $past(sel.nib[3:2])))
    else $error("row enable does not match code");

endmodule

/* tb/ebad_cpu_model.sv */
// Purpose: Bus master side of the board: multiplexed address and commands
// Assumes: Drives pins at the falling edge of i_clock
// Notes: Released write data shows the inverse of its last value
`timescale 1ns/1ps
module ebad_cpu_model (
  input wire logic i_clock,
  output logic [7:0] o_mux_addr,
  output logic o_strobe,
  output logic o_tpb,
  output logic o_read_n,
  output logic o_write_n,
  output logic [7:0] o_data
);
  initial begin
    o_mux_addr = 8'h00;
    o_strobe = 1'b0;
    o_tpb = 1'b0;
    o_read_n = 1'b1;
    o_write_n = 1'b1;
    o_data = 8'h00;
  end

  // High byte with the strobe, then low byte on the same lines
  task automatic start(input logic [7:0] hi, input logic [7:0] lo,
                       input logic wr, input logic [7:0] dat);
    @(negedge i_clock);
    o_mux_addr = hi;
    o_strobe = 1'b1;
    repeat (3) @(negedge i_clock);
    o_strobe = 1'b0;
    repeat (3) @(negedge i_clock);
    o_mux_addr = lo;
    repeat (2) @(negedge i_clock);
    if (wr) begin
      o_write_n = 1'b0;
      o_data = dat;
      repeat (4) @(negedge i_clock);
      o_tpb = 1'b1;
      repeat (3) @(negedge i_clock);
      o_tpb = 1'b0;
    end else begin
      o_read_n = 1'b0;
    end
    repeat (8) @(negedge i_clock);
  endtask

  task automatic set_addr(input logic [7:0] v);
    @(negedge i_clock);
    o_mux_addr = v;
    repeat (5) @(negedge i_clock);
  endtask

  task automatic finish();
    @(negedge i_clock);
    o_read_n = 1'b1;
    o_write_n = 1'b1;
    o_data = ~o_data;
    repeat (8) @(negedge i_clock);
  endtask
endmodule

/* tb/testbench.sv */
// Purpose: Self-checking bench of the board address decoder
// Assumes: Fixed waits follow the pin-to-output latencies of the design
// Notes: Table rows cover block match, boot force and every column and row code
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
    logic [3:0] sw;
    logic boot;
    logic [3:0] col;
    logic [3:0] row_n;
    logic oe;
  } ebad_row_t;
  localparam ebad_row_t ROWS [8] = '{
    '{8'h30, 8'h11, 4'h3, 1'b0, 4'h1, 4'he, 1'b1},
    '{8'h3f, 8'hff, 4'h3, 1'b0, 4'h8, 4'h7, 1'b1},
    '{8'h36, 8'h00, 4'h3, 1'b0, 4'h4, 4'hd, 1'b1},
    '{8'h39, 8'h5a, 4'h3, 1'b0, 4'h2, 4'hb, 1'b1},
    '{8'h43, 8'h22, 4'h3, 1'b0, 4'h0, 4'hf, 1'b0},
    '{8'h35, 8'h81, 4'hb, 1'b1, 4'h2, 4'hd, 1'b1},
    '{8'hfc, 8'h7e, 4'hf, 1'b0, 4'h1, 4'h7, 1'b1},
    '{8'h0a, 8'h3c, 4'h0, 1'b0, 4'h4, 4'hb, 1'b1}};
  logic i_clock = 1'b0;
  logic i_reset = 1'b1;
  logic i_boot_high_force = 1'b0;
  logic [3:0] i_board_switch = 4'h0;
  logic i_mode_prog_switch = 1'b0;
  logic [7:0] i_socket_data = 8'h00;
  logic [7:0] mux, dat, o_data, o_socket_addr, o_prog_data;
  logic stb, second_timing_pulse, rd_n, wr_n, o_data_oe, o_board_enable;
  logic o_erase_verify, o_prog_active, o_prog_strobe;
  logic [3:0] o_column_select, o_row_enable_n;
  int n_errors = 0;
  int checks = 0;
  int n_pulses = 0;

  ebad_cpu_model ebad_cpu_model_i (.i_clock(i_clock), .o_mux_addr(mux),
    .o_strobe(stb), .o_tpb(second_timing_pulse), .o_read_n(rd_n), .o_write_n(wr_n),
    .o_data(dat));
  ebad_top ebad_top_i (.i_clock(i_clock), .i_reset(i_reset),
    .i_mux_addr(mux), .i_address_strobe_pulse(stb),
    .i_second_timing_pulse(second_timing_pulse), .i_mem_read_cmd_n(rd_n),
    .i_mem_write_cmd_n(wr_n), .i_boot_high_force(i_boot_high_force),
    .i_board_switch(i_board_switch), .i_mode_prog_switch(i_mode_prog_switch),
    .i_socket_data(i_socket_data), .i_data(dat), .o_data(o_data),
    .o_data_oe(o_data_oe), .o_socket_addr(o_socket_addr),
    .o_column_select(o_column_select), .o_row_enable_n(o_row_enable_n),
    .o_board_enable(o_board_enable), .o_erase_verify(o_erase_verify),
    .o_prog_active(o_prog_active), .o_prog_strobe(o_prog_strobe),
    .o_prog_data(o_prog_data));

  initial begin
    forever #5 i_clock = ~i_clock;
  end

  always @(posedge i_clock) begin
    if (o_prog_strobe === 1'b1) n_pulses++;
  end

  task automatic check(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic idle_check();
    check("col_idle", {4'h0, o_column_select}, 8'h00);
    check("row_idle", {4'h0, o_row_enable_n}, 8'h0f);
    check("oe_idle", {7'h00, o_data_oe}, 8'h00);
  endtask

  task automatic summarize();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge i_clock);
    n_errors++;
    summarize();
  end

  initial begin
    repeat (10) @(negedge i_clock);
    idle_check();
    check("enable_rst", {7'h00, o_board_enable}, 8'h00);
    check("prog_rst", {6'h00, o_prog_active, o_prog_strobe}, 8'h00);
    i_reset = 1'b0;
    foreach (ROWS[k]) begin
      @(negedge i_clock);
      i_board_switch = ROWS[k].sw;
      i_boot_high_force = ROWS[k].boot;
      i_socket_data = ROWS[k].lo ^ 8'ha5;
      ebad_cpu_model_i.start(ROWS[k].hi, ROWS[k].lo, 1'b0, 8'h00);
      check("enable", {7'h00, o_board_enable}, {7'h00, ROWS[k].oe});
      check("col", {4'h0, o_column_select}, {4'h0, ROWS[k].col});
      check("row", {4'h0, o_row_enable_n}, {4'h0, ROWS[k].row_n});
      check("oe", {7'h00, o_data_oe}, {7'h00, ROWS[k].oe});
      check("low_addr", o_socket_addr, ROWS[k].lo);
      check("rdata", o_data, ROWS[k].lo ^ 8'ha5);
      ebad_cpu_model_i.finish();
      idle_check();
    end
    // Write in read position: selects, held low address, no programming
    i_boot_high_force = 1'b0;
    i_board_switch = 4'h7;
    ebad_cpu_model_i.start(8'h75, 8'h44, 1'b1, 8'hc3);
    ebad_cpu_model_i.set_addr(8'h99);
    check("wr_addr", o_socket_addr, 8'h44);
    check("wr_col", {4'h0, o_column_select}, 8'h02);
    check("wr_oe", {7'h00, o_data_oe}, 8'h00);
    check("rd_pulses", n_pulses[7:0], 8'h00);
    ebad_cpu_model_i.finish();
    i_mode_prog_switch = 1'b1;
    repeat (6) @(negedge i_clock);
    check("verify", {6'h00, o_erase_verify, o_prog_active}, 8'h02);
    ebad_cpu_model_i.start(8'h7e, 8'hf0, 1'b1, 8'h5a);
    check("prog_mode", {6'h00, o_erase_verify, o_prog_active}, 8'h01);
    check("pulses", n_pulses[7:0], 8'h01);
    check("prog_data", o_prog_data, 8'h5a);
    ebad_cpu_model_i.finish();
    ebad_cpu_model_i.start(8'h7e, 8'hf0, 1'b0, 8'h00);
    check("back_verify", {7'h00, o_erase_verify}, 8'h01);
    ebad_cpu_model_i.finish();
    // Switch moved away from the latched block drops the match
    i_board_switch = 4'h6;
    ebad_cpu_model_i.start(8'h7e, 8'hf0, 1'b0, 8'h00);
    check("sw_change", {7'h00, o_board_enable}, 8'h00);
    ebad_cpu_model_i.finish();
    idle_check();
    // Reset in mid-read: selects drop, match waits for a new strobe
    i_board_switch = 4'h7;
    ebad_cpu_model_i.start(8'h7e, 8'hf0, 1'b0, 8'h00);
    check("pre_rst", {7'h00, o_data_oe}, 8'h01);
    i_reset = 1'b1;
    repeat (3) @(negedge i_clock);
    i_reset = 1'b0;
    idle_check();
    check("mode_rst", {6'h00, o_erase_verify, o_prog_active}, 8'h00);
    repeat (6) @(negedge i_clock);
    idle_check();
    check("enable_mid", {7'h00, o_board_enable}, 8'h00);
    check("mid_pulses", n_pulses[7:0], 8'h01);
    ebad_cpu_model_i.finish();
    summarize();
  end
endmodule
